// *** ltal_map.svh ***
// Register offsets, field positions, reset values and codes for the light threshold alert logic
`ifndef LTAL_MAP_SVH
`define LTAL_MAP_SVH
`define LTAL_OFF_RESULT 8'h00
`define LTAL_OFF_CONFIG 8'h01
`define LTAL_OFF_LOW 8'h02
`define LTAL_OFF_HIGH 8'h03
`define LTAL_LOW_RESET 16'h0000
`define LTAL_HIGH_RESET 16'hBFFF
`define LTAL_CFG_RESET 16'hC810
`define LTAL_CFG_RW_MASK 16'hFE1F
`define LTAL_EXP_MSB 15
`define LTAL_EXP_LSB 12
`define LTAL_MAN_MSB 11
`define LTAL_MAN_LSB 0
`define LTAL_RANGE_MSB 15
`define LTAL_RANGE_LSB 12
`define LTAL_MODE_MSB 10
`define LTAL_MODE_LSB 9
`define LTAL_BIT_READY 7
`define LTAL_BIT_HIGH_FLAG 6
`define LTAL_BIT_LOW_FLAG 5
`define LTAL_BIT_LATCH 4
`define LTAL_BIT_POL 3
`define LTAL_BIT_MASK 2
`define LTAL_FC_MSB 1
`define LTAL_FC_LSB 0
`define LTAL_RANGE_AUTO 4'hC
`define LTAL_MODE_SHUTDOWN 2'h0
`define LTAL_EXP_ZERO 4'h0
`define LTAL_FC_ONE 2'h0
`define LTAL_FC_TWO 2'h1
`define LTAL_FC_FOUR 2'h2
`define LTAL_CNT_ONE 4'h1
`define LTAL_CNT_TWO 4'h2
`define LTAL_CNT_FOUR 4'h4
`define LTAL_CNT_EIGHT 4'h8
`define LTAL_CNT_ZERO 4'h0
`endif

// *** ltal_pkg.sv ***
// Types shared by the light threshold alert logic
package ltal_pkg;
    typedef logic [15:0] ltal_word_t;
    typedef logic [26:0] ltal_lux_t;
    typedef enum logic [1:0] {
        LTAL_ST_IDLE = 2'b01,
        LTAL_ST_ALERT = 2'b10
    } ltal_alert_state_t;
endpackage

// *** ltal_cmp_if.sv ***
// Interface carrying one comparison channel between the top and its fault counter
`timescale 1ns/1ps
interface ltal_cmp_if;
    logic sample;
    logic violate;
    logic [3:0] need;
    logic hit;
    modport top (output sample, output violate, output need, input hit);
    modport cnt (input sample, input violate, input need, output hit);
endinterface

// *** ltal_fault_counter.sv ***
// Consecutive fault counter for one threshold comparison
`timescale 1ns/1ps
`include "ltal_map.svh"
module ltal_fault_counter (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_i,
    // Comparison channel
    ltal_cmp_if.cnt ch
);
    logic [3:0] count_reg;
    logic [3:0] count_next;

    always_comb begin
        count_next = count_reg;
        if (ch.sample) begin
            if (!ch.violate) begin
                count_next = `LTAL_CNT_ZERO;
            end else if (count_reg < ch.need) begin
                count_next = count_reg + `LTAL_CNT_ONE;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            count_reg <= `LTAL_CNT_ZERO;
        end else begin
            count_reg <= count_next;
        end
    end

    // Hit is a pulse on the conversion that reaches the count; saturation repeats the pulse on each later faulting conversion
    assign ch.hit = ch.sample && ch.violate && (count_next >= ch.need);
endmodule

// *** ltal_alert_logic.sv ***
// Threshold comparison and alert reporting for an ambient light measurement device
// Overview of operation
// - Low flag sets after enough consecutive low results
// - Latch zero: pin and flags follow comparison
// - Latch one: hold alert until host clears
// - Polarity zero: alert drives pin low
// - Polarity one: alert releases pin, pullup raises
// - Mask with manual range zeroes result exponent
// - Masking affects result read only, not compare
// - Fault count codes select one, two, four, eight
// - Low threshold: exponent 15:12, mantissa 11:0
// - Threshold lux is 0.01 times 2^exp times mantissa
// - Exponent codes 0 to 11 double scale
// - Result and thresholds compared on common scale
// - High flag sets after enough consecutive high results
// - High threshold same layout, resets to BFFF
// - Shutdown leaves flags and pin unchanged
`timescale 1ns/1ps
`include "ltal_map.svh"
module ltal_alert_logic (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_i,
    // Conversion result from the converter
    input wire logic conv_done_i,
    input wire logic [15:0] conv_result_i,
    // Register port from the serial interface
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [15:0] reg_wdata_i,
    output logic [15:0] reg_rdata_o,
    // Alert pin, open drain
    input wire logic alert_pin_i,
    output logic alert_pin_o,
    output logic alert_pin_oe_o
);
    ltal_pkg::ltal_word_t low_reg, low_next;
    ltal_pkg::ltal_word_t high_reg, high_next;
    ltal_pkg::ltal_word_t cfg_reg, cfg_next;
    ltal_pkg::ltal_word_t result_reg, result_next;
    ltal_pkg::ltal_word_t rdata_reg, rdata_next;
    logic low_flag_reg, low_flag_next;
    logic high_flag_reg, high_flag_next;
    logic ready_reg, ready_next;
    ltal_pkg::ltal_alert_state_t state_reg, state_next;

    ltal_cmp_if low_ch();
    ltal_cmp_if high_ch();

    // Expand exponent and mantissa to lux in 0.01 lux units; 12-bit mantissa shifted by up to 15
    function automatic ltal_pkg::ltal_lux_t to_lux(input ltal_pkg::ltal_word_t w);
        ltal_pkg::ltal_lux_t m;
        m = {15'h0000, w[`LTAL_MAN_MSB:`LTAL_MAN_LSB]};
        return m << w[`LTAL_EXP_MSB:`LTAL_EXP_LSB];
    endfunction

    ltal_pkg::ltal_lux_t res_lux, low_lux, high_lux;
    logic [1:0] fc;
    logic [3:0] need;
    logic latch_en, alert_polarity, mask_en;
    logic cfg_access, clear_evt;

    assign latch_en = cfg_reg[`LTAL_BIT_LATCH];
    assign alert_polarity = cfg_reg[`LTAL_BIT_POL];
    assign mask_en = cfg_reg[`LTAL_BIT_MASK];
    assign fc = cfg_reg[`LTAL_FC_MSB:`LTAL_FC_LSB];
    // Compare unmasked conversion word against both limits in lux
    assign res_lux = to_lux(conv_result_i);
    assign low_lux = to_lux(low_reg);
    assign high_lux = to_lux(high_reg);

    always_comb begin
        case (fc)
            `LTAL_FC_ONE: need = `LTAL_CNT_ONE;
            `LTAL_FC_TWO: need = `LTAL_CNT_TWO;
            `LTAL_FC_FOUR: need = `LTAL_CNT_FOUR;
            default: need = `LTAL_CNT_EIGHT;
        endcase
    end

    assign low_ch.sample = conv_done_i;
    assign low_ch.violate = res_lux < low_lux;
    assign low_ch.need = need;
    assign high_ch.sample = conv_done_i;
    assign high_ch.violate = res_lux > high_lux;
    assign high_ch.need = need;

    ltal_fault_counter u_low_cnt (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .ch(low_ch)
    );

    ltal_fault_counter u_high_cnt (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .ch(high_ch)
    );

    // Any read of configuration, or a write that is not shutdown, is the host clearing event
    assign cfg_access = (reg_addr_i == `LTAL_OFF_CONFIG);
    assign clear_evt = cfg_access && (reg_rd_i ||
        (reg_wr_i && reg_wdata_i[`LTAL_MODE_MSB:`LTAL_MODE_LSB] != `LTAL_MODE_SHUTDOWN));

    // Register file
    always_comb begin
        low_next = low_reg;
        high_next = high_reg;
        cfg_next = cfg_reg;
        result_next = result_reg;
        if (reg_wr_i) begin
            if (reg_addr_i == `LTAL_OFF_LOW) begin
                low_next = reg_wdata_i;
            end else if (reg_addr_i == `LTAL_OFF_HIGH) begin
                high_next = reg_wdata_i;
            end else if (cfg_access) begin
                cfg_next = (reg_wdata_i & `LTAL_CFG_RW_MASK) | (cfg_reg & ~`LTAL_CFG_RW_MASK);
            end
        end
        if (conv_done_i) begin
            result_next = conv_result_i;
            // Masking only touches the stored read value; the compare path sees conv_result_i
            if (mask_en && cfg_reg[`LTAL_RANGE_MSB:`LTAL_RANGE_LSB] < `LTAL_RANGE_AUTO) begin
                result_next[`LTAL_EXP_MSB:`LTAL_EXP_LSB] = `LTAL_EXP_ZERO;
            end
        end
    end

    // Flags and alert state; a new hit wins over a simultaneous clear
    always_comb begin
        low_flag_next = low_flag_reg;
        high_flag_next = high_flag_reg;
        ready_next = ready_reg;
        state_next = state_reg;
        if (clear_evt) begin
            ready_next = 1'b0;
        end
        if (conv_done_i) begin
            ready_next = 1'b1;
        end
        if (!latch_en) begin
            // Transparent mode: flags reflect each conversion outcome
            if (conv_done_i) begin
                low_flag_next = low_ch.hit;
                high_flag_next = high_ch.hit;
                state_next = (low_ch.hit || high_ch.hit) ? ltal_pkg::LTAL_ST_ALERT : ltal_pkg::LTAL_ST_IDLE;
            end
        end else begin
            if (clear_evt) begin
                low_flag_next = 1'b0;
                high_flag_next = 1'b0;
                state_next = ltal_pkg::LTAL_ST_IDLE;
            end
            if (low_ch.hit) begin
                low_flag_next = 1'b1;
            end
            if (high_ch.hit) begin
                high_flag_next = 1'b1;
            end
            case (state_reg)
                ltal_pkg::LTAL_ST_IDLE: begin
                    if (low_ch.hit || high_ch.hit) begin
                        state_next = ltal_pkg::LTAL_ST_ALERT;
                    end
                end
                ltal_pkg::LTAL_ST_ALERT: begin
                    if (low_ch.hit || high_ch.hit) begin
                        state_next = ltal_pkg::LTAL_ST_ALERT;
                    end
                end
                default: state_next = ltal_pkg::LTAL_ST_IDLE;
            endcase
        end
    end

    // Read data with live flag bits
    always_comb begin
        rdata_next = rdata_reg;
        if (reg_rd_i) begin
            if (reg_addr_i == `LTAL_OFF_RESULT) begin
                rdata_next = result_reg;
            end else if (cfg_access) begin
                rdata_next = cfg_reg;
                rdata_next[`LTAL_BIT_READY] = ready_reg;
                rdata_next[`LTAL_BIT_HIGH_FLAG] = high_flag_reg;
                rdata_next[`LTAL_BIT_LOW_FLAG] = low_flag_reg;
            end else if (reg_addr_i == `LTAL_OFF_LOW) begin
                rdata_next = low_reg;
            end else if (reg_addr_i == `LTAL_OFF_HIGH) begin
                rdata_next = high_reg;
            end else begin
                rdata_next = `LTAL_LOW_RESET;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            low_reg <= `LTAL_LOW_RESET;
            high_reg <= `LTAL_HIGH_RESET;
            cfg_reg <= `LTAL_CFG_RESET;
            result_reg <= `LTAL_LOW_RESET;
            rdata_reg <= `LTAL_LOW_RESET;
            low_flag_reg <= 1'b0;
            high_flag_reg <= 1'b0;
            ready_reg <= 1'b0;
            state_reg <= ltal_pkg::LTAL_ST_IDLE;
        end else begin
            low_reg <= low_next;
            high_reg <= high_next;
            cfg_reg <= cfg_next;
            result_reg <= result_next;
            rdata_reg <= rdata_next;
            low_flag_reg <= low_flag_next;
            high_flag_reg <= high_flag_next;
            ready_reg <= ready_next;
            state_reg <= state_next;
        end
    end

    // Open drain: only ever drive low; the pullup supplies the high level
    logic alert_active;
    assign alert_active = (state_reg == ltal_pkg::LTAL_ST_ALERT);
    assign alert_pin_o = 1'b0;
    assign alert_pin_oe_o = alert_polarity ? !alert_active : alert_active;
    assign reg_rdata_o = rdata_reg;
endmodule

// *** ltal_alert_pullup.sv ***
// Pulled-up alert line as seen by the host
`timescale 1ns/1ps
module ltal_alert_pullup (
    // Device side
    input wire logic drive_i,
    input wire logic drive_oe_i,
    // Line level
    output logic line_o
);
    // A released line floats up through the pullup, never holding its last value
    assign line_o = drive_oe_i ? drive_i : 1'b1;
endmodule

// *** ltal_alert_logic_properties.sv ***
// Port checker for the light threshold alert logic
`timescale 1ns/1ps
module ltal_alert_logic_properties (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_i,
    // Inputs
    input wire logic conv_done_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [15:0] reg_wdata_i,
    // Outputs
    input wire logic [15:0] reg_rdata_o,
    input wire logic alert_pin_o,
    input wire logic alert_pin_oe_o
);
    default clocking @(posedge ref_clk_i); endclocking
    a_reset_idle: assert property (reset_i |=> !alert_pin_oe_o && reg_rdata_o == 16'h0000)
        else $error("pin or read data busy after reset");
    a_pin_low_drive: assert property (disable iff (reset_i) alert_pin_o == 1'b0)
        else $error("alert pin driven high");
    a_unmapped_zero: assert property (disable iff (reset_i) reg_rd_i && reg_addr_i > 8'h03 |=> reg_rdata_o == 16'h0000)
        else $error("unmapped read not zero");
    a_rdata_hold: assert property (disable iff (reset_i) !reg_rd_i |=> $stable(reg_rdata_o))
        else $error("read data moved without a read");
    // With active-high polarity a clearing read releases the alert, which raises the drive enable
    a_oe_raise_cause: assert property (disable iff (reset_i) $rose(alert_pin_oe_o) |->
        $past(conv_done_i || reg_rd_i || reg_wr_i) || $past(conv_done_i || reg_rd_i || reg_wr_i, 2))
        else $error("alert raised without conversion or register access");
    a_oe_fall_cause: assert property (disable iff (reset_i) $fell(alert_pin_oe_o) |->
        $past(conv_done_i || reg_rd_i || reg_wr_i) || $past(conv_done_i || reg_rd_i || reg_wr_i, 2))
        else $error("alert dropped without cause");
    a_low_read_back: assert property (disable iff (reset_i) reg_wr_i && reg_addr_i == 8'h02 ##1 !reg_wr_i
        ##1 reg_rd_i && reg_addr_i == 8'h02 |=> reg_rdata_o == $past(reg_wdata_i, 3))
        else $error("low threshold read back differs");
    a_high_read_back: assert property (disable iff (reset_i) reg_wr_i && reg_addr_i == 8'h03 ##1 !reg_wr_i
        ##1 reg_rd_i && reg_addr_i == 8'h03 |=> reg_rdata_o == $past(reg_wdata_i, 3))
        else $error("high threshold read back differs");
    c_alert: cover property (conv_done_i ##[1:2] alert_pin_oe_o);
    c_cfg_read: cover property (reg_rd_i && reg_addr_i == 8'h01);
    c_clear: cover property ($fell(alert_pin_oe_o));
endmodule

// *** ltal_alert_logic_test.sv ***
// Self-checking testbench for the light threshold alert logic
`timescale 1ns/1ps
module ltal_alert_logic_test;
    logic ref_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic conv_done_i = 1'b0;
    logic [15:0] conv_result_i = 16'h0000;
    logic [7:0] reg_addr_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [15:0] reg_wdata_i = 16'h0000;
    logic [15:0] reg_rdata_o;
    logic alert_pin_o;
    logic alert_pin_oe_o;
    logic alert_pin;
    int bad_count = 0;
    int num_checks = 0;
    int cycles = 0;
    always #12.5 ref_clk_i = ~ref_clk_i;
    ltal_alert_logic i_ltal_alert_logic (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .conv_done_i(conv_done_i),
        .conv_result_i(conv_result_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .alert_pin_i(alert_pin),
        .alert_pin_o(alert_pin_o), .alert_pin_oe_o(alert_pin_oe_o));
    ltal_alert_pullup i_ltal_alert_pullup (.drive_i(alert_pin_o), .drive_oe_i(alert_pin_oe_o), .line_o(alert_pin));
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic pin(input logic exp);
        repeat (2) @(posedge ref_clk_i);
        #1 chk({15'h0000, alert_pin}, {15'h0000, exp});
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b0;
        @(posedge ref_clk_i);
        #1 chk(reg_rdata_o, exp);
    endtask
    task automatic conv(input logic [15:0] r, input logic exp);
        @(posedge ref_clk_i);
        conv_result_i <= r;
        conv_done_i <= 1'b1;
        @(posedge ref_clk_i);
        conv_done_i <= 1'b0;
        pin(exp);
    endtask
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            end_of_test();
        end
    end
    initial begin
        repeat (4) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        rd(8'h01, 16'hC810);
        rd(8'h03, 16'hBFFF);
        rd(8'h05, 16'h0000);
        wr(8'h02, 16'h0200);
        rd(8'h02, 16'h0200);
        $display("test reset done");
        wr(8'h01, 16'hCC10);
        conv(16'h01FF, 1'b0);
        conv(16'h0300, 1'b0);
        rd(8'h01, 16'hCCB0);
        conv(16'h0300, 1'b1);
        conv(16'h2080, 1'b1);
        conv(16'h207F, 1'b0);
        wr(8'h01, 16'h0C14);
        conv(16'h2100, 1'b1);
        rd(8'h00, 16'h0100);
        $display("test latched done");
        for (int i = 0; i < 4; i++) begin
            wr(8'h01, 16'hCC00 | 16'(i));
            conv(16'h0300, 1'b1);
            repeat ((1 << i) - 1) conv(16'h0001, 1'b1);
            conv(16'h0001, 1'b0);
            conv(16'h0300, 1'b1);
        end
        $display("test fault count done");
        wr(8'h01, 16'hCC00);
        wr(8'h03, 16'h0300);
        rd(8'h03, 16'h0300);
        conv(16'h0301, 1'b0);
        rd(8'h01, 16'hCCC0);
        wr(8'h01, 16'hCC10);
        conv(16'h0301, 1'b0);
        wr(8'h01, 16'hC810);
        pin(1'b0);
        rd(8'h01, 16'hC8D0);
        wr(8'h01, 16'hCC08);
        conv(16'h0250, 1'b0);
        conv(16'h0301, 1'b1);
        // Top exponent against the next one down: equal lux must not trip, one step more must
        wr(8'h03, 16'hB001);
        conv(16'hA002, 1'b0);
        conv(16'hA003, 1'b1);
        $display("test high and polarity done");
        end_of_test();
    end
endmodule
bind ltal_alert_logic ltal_alert_logic_properties i_ltal_alert_logic_properties (.ref_clk_i(ref_clk_i),
    .reset_i(reset_i), .conv_done_i(conv_done_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .alert_pin_o(alert_pin_o),
    .alert_pin_oe_o(alert_pin_oe_o));
